// ---- interval_timer_map.vh ----
// register map, field positions, reset values and timing counts of the interval timer
`ifndef INTERVAL_TIMER_MAP_VH
`define INTERVAL_TIMER_MAP_VH

`define OFS_TIMER_CONTROL 8'h00
`define OFS_COMPARE_A_LOW 8'h04
`define OFS_COMPARE_A_HIGH 8'h08
`define OFS_COMPARE_A 8'h0c
`define OFS_CAPTURE_B 8'h10
`define OFS_STATUS 8'h14
`define OFS_COUNT 8'h18

`define CTRL_MODE_LSB 0
`define CTRL_START_LSB 2
`define CTRL_CLKSEL_LSB 4
`define CTRL_ACAP_BIT 6
`define CTRL_TRIG_STOP_BIT 7
`define CTRL_DIV_TAP_BIT 8
`define CTRL_LOW_SPEED_BIT 9
`define CTRL_WIDTH 10
`define CTRL_RESET 10'h000

`define START_STOP 2'h0
`define START_COMMAND 2'h1
`define START_RISING 2'h2
`define START_FALLING 2'h3

`define MODE_TIMER 2'h0

`define CLKSEL_DIV11 2'h0
`define CLKSEL_DIV7 2'h1
`define CLKSEL_DIV3 2'h2
`define CLKSEL_PIN 2'h3

`define COMPARE_RESET 16'hffff
`define CAPTURE_RESET 16'h0000

// noise rejection in units of 1/fc; the system clock is fc itself
`define NOISE_REJECT_FC 4
`define SYS_CYCLES_PER_FC 1
`define NOISE_REJECT_CYC (`NOISE_REJECT_FC * `SYS_CYCLES_PER_FC)

`endif

// ---- trigger_noise_filter.v ----
// noise rejection filter for the trigger input pin
`timescale 1ns/10ps
module trigger_noise_filter #(
    parameter REJECT = 4,
    parameter CW = 4
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_raw,
    input wire i_bypass,
    output wire o_filtered
);
    reg filt_reg;
    reg [CW-1:0] cnt_reg;

    assign o_filtered = filt_reg;

    // level must differ for REJECT+1 cycles before it is accepted
    always @(posedge i_clk) begin
        if (i_rst) begin
            filt_reg <= 1'b0;
            cnt_reg <= {CW{1'b0}};
        end else if (i_bypass) begin
            filt_reg <= i_raw;
            cnt_reg <= {CW{1'b0}};
        end else if (i_raw == filt_reg) begin
            cnt_reg <= {CW{1'b0}};
        end else if (cnt_reg == REJECT[CW-1:0]) begin
            filt_reg <= i_raw;
            cnt_reg <= {CW{1'b0}};
        end else begin
            cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
        end
    end
endmodule // trigger_noise_filter

// ---- interval_trigger_timer.v ----
// interval and external trigger timer with ahb-lite register slave
// Behaviour
// - timer mode counts every source clock tick, ignoring the trigger pin.
// - timer mode match with compare A raises interrupt, clears counter, keeps counting.
// - auto-capture enabled copies counter into capture B on each source tick.
// - trigger mode holds counter until trigger edge, then counts source ticks.
// - start field picks rising or falling trigger edge.
// - trigger mode match clears and halts counter and raises interrupt.
// - with stop select, opposite edge before match clears and halts, no interrupt.
// - with stop select, halted counter restarts at next trigger edge.
// - without stop select, opposite edges do nothing.
// - without stop select, trigger edge while counting is ignored.
// - normal clock: trigger pulses of 4/fc or shorter are rejected.
// - low-speed mode bypasses the filter; source holds level one machine cycle.
// - clock select: fc/2^11 or fs/2^3, fc/2^7, fc/2^3, or pin clock.
// - compare A takes low then high byte, applied at next source tick.
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "interval_timer_map.vh"
module interval_trigger_timer #(
    parameter W = 16
) (
    input wire I_CLK_SYS,
    input wire I_RST,
    input wire I_HSEL,
    input wire [31:0] I_HADDR,
    input wire [1:0] I_HTRANS,
    input wire I_HWRITE,
    input wire [2:0] I_HSIZE,
    input wire [31:0] I_HWDATA,
    input wire I_HREADY,
    output wire [31:0] O_HRDATA,
    output wire O_HREADYOUT,
    output wire O_HRESP,
    input wire I_TRIGGER_INPUT_PIN,
    input wire I_LOW_CLK_TICK,
    output wire O_MATCH_INTERRUPT
);
    // bus state
    reg [7:0] addr_reg;
    reg dphase_wr_reg;
    reg dphase_rd_reg;
    reg rd_ready_reg;
    reg [31:0] hrdata_reg;
    reg [31:0] rd_mux;

    // registers
    reg [`CTRL_WIDTH-1:0] ctrl_reg;
    reg [7:0] stage_low_reg;
    reg [7:0] stage_high_reg;
    reg pending_reg;
    reg [W-1:0] compare_a_reg;
    reg [W-1:0] capture_b_reg;

    // timer state
    reg [W-1:0] count_reg;
    reg running_reg;
    reg irq_reg;
    reg [10:0] div_reg;
    reg [2:0] fs_div_reg;
    reg sync1_reg;
    reg sync2_reg;
    reg prev_reg;
    reg tick;

    wire filtered;
    wire addr_take;
    wire wr_now;
    wire [1:0] mode = ctrl_reg[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
    wire [1:0] start = ctrl_reg[`CTRL_START_LSB+1:`CTRL_START_LSB];
    wire [1:0] clksel = ctrl_reg[`CTRL_CLKSEL_LSB+1:`CTRL_CLKSEL_LSB];
    wire acap = ctrl_reg[`CTRL_ACAP_BIT];
    wire trig_stop = ctrl_reg[`CTRL_TRIG_STOP_BIT];
    wire div_tap = ctrl_reg[`CTRL_DIV_TAP_BIT];
    wire low_speed = ctrl_reg[`CTRL_LOW_SPEED_BIT];
    wire pin_rise = sync2_reg & ~prev_reg;
    wire pin_fall = ~sync2_reg & prev_reg;
    wire trig_edge;
    wire opp_edge;
    wire fs_tick;
    wire match;
    wire active;

    // ahb-lite slave: writes zero wait, reads one wait state
    assign O_HREADYOUT = ~(dphase_rd_reg & ~rd_ready_reg);
    assign O_HRESP = 1'b0;
    assign O_HRDATA = hrdata_reg;
    assign O_MATCH_INTERRUPT = irq_reg;
    assign addr_take = I_HSEL & I_HTRANS[1] & I_HREADY;
    assign wr_now = dphase_wr_reg;

    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            addr_reg <= 8'h00;
            dphase_wr_reg <= 1'b0;
            dphase_rd_reg <= 1'b0;
            rd_ready_reg <= 1'b0;
            hrdata_reg <= 32'h00000000;
        end else begin
            if (dphase_rd_reg & ~rd_ready_reg) begin
                // read sampled in data phase so a preceding write is visible
                hrdata_reg <= rd_mux;
                rd_ready_reg <= 1'b1;
            end else if (addr_take) begin
                addr_reg <= {I_HADDR[7:2], 2'b00};
                dphase_wr_reg <= I_HWRITE;
                dphase_rd_reg <= ~I_HWRITE;
                rd_ready_reg <= 1'b0;
            end else if (I_HREADY) begin
                dphase_wr_reg <= 1'b0;
                dphase_rd_reg <= 1'b0;
                rd_ready_reg <= 1'b0;
            end
        end
    end

    always @* begin
        rd_mux = 32'h00000000;
        case (addr_reg)
            `OFS_TIMER_CONTROL: rd_mux = {{(32-`CTRL_WIDTH){1'b0}}, ctrl_reg};
            `OFS_COMPARE_A_LOW: rd_mux = {24'h000000, stage_low_reg};
            `OFS_COMPARE_A_HIGH: rd_mux = {24'h000000, stage_high_reg};
            `OFS_COMPARE_A: rd_mux = {{(32-W){1'b0}}, compare_a_reg};
            `OFS_CAPTURE_B: rd_mux = {{(32-W){1'b0}}, capture_b_reg};
            `OFS_STATUS: rd_mux = {29'h00000000, sync2_reg, pending_reg, running_reg};
            `OFS_COUNT: rd_mux = {{(32-W){1'b0}}, count_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // writable registers; compare A staged through two byte registers
    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            ctrl_reg <= `CTRL_RESET;
            stage_low_reg <= 8'h00;
            stage_high_reg <= 8'h00;
            pending_reg <= 1'b0;
            compare_a_reg <= `COMPARE_RESET;
        end else begin
            if (tick & pending_reg) begin
                compare_a_reg <= {stage_high_reg, stage_low_reg};
                pending_reg <= 1'b0;
            end
            if (wr_now) begin
                case (addr_reg)
                    `OFS_TIMER_CONTROL: ctrl_reg <= I_HWDATA[`CTRL_WIDTH-1:0];
                    `OFS_COMPARE_A_LOW: stage_low_reg <= I_HWDATA[7:0];
                    `OFS_COMPARE_A_HIGH: begin
                        stage_high_reg <= I_HWDATA[7:0];
                        // a new high write beats the apply in the same cycle
                        pending_reg <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // noise filter, bypassed in low-speed operation
    trigger_noise_filter #(
        .REJECT(`NOISE_REJECT_CYC),
        .CW(4)
    ) u_filter (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_raw(I_TRIGGER_INPUT_PIN),
        .i_bypass(low_speed),
        .o_filtered(filtered)
    );

    // synchroniser and edge sampler after the filter
    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            sync1_reg <= filtered;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign trig_edge = (start == `START_RISING) ? pin_rise : pin_fall;
    assign opp_edge = (start == `START_RISING) ? pin_fall : pin_rise;

    // source clock prescaler, always running
    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            div_reg <= 11'h000;
            fs_div_reg <= 3'h0;
        end else begin
            div_reg <= div_reg + 11'h001;
            if (I_LOW_CLK_TICK) begin
                fs_div_reg <= fs_div_reg + 3'h1;
            end
        end
    end

    assign fs_tick = I_LOW_CLK_TICK & (fs_div_reg == 3'h7);

    always @* begin
        tick = 1'b0;
        case (clksel)
            `CLKSEL_DIV11: tick = (div_tap | low_speed) ? fs_tick : (div_reg == 11'h7ff);
            `CLKSEL_DIV7: tick = ~low_speed & (div_reg[6:0] == 7'h7f);
            `CLKSEL_DIV3: tick = ~low_speed & (div_reg[2:0] == 3'h7);
            `CLKSEL_PIN: tick = pin_rise;
            default: tick = 1'b0;
        endcase
    end

    assign match = (count_reg == compare_a_reg);
    assign active = (mode == `MODE_TIMER) & (start != `START_STOP);

    // counter; only timer and external trigger behaviour is built
    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            count_reg <= {W{1'b0}};
            running_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= 1'b0;
            if (~active) begin
                count_reg <= {W{1'b0}};
                running_reg <= 1'b0;
            end else if (start == `START_COMMAND) begin
                running_reg <= 1'b1;
                if (tick) begin
                    if (match) begin
                        count_reg <= {W{1'b0}};
                        irq_reg <= 1'b1;
                    end else begin
                        count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
                    end
                end
            end else if (~running_reg) begin
                // halted: wait for the trigger edge, count held at zero
                if (trig_edge) begin
                    running_reg <= 1'b1;
                end
            end else if (trig_stop & opp_edge) begin
                count_reg <= {W{1'b0}};
                running_reg <= 1'b0;
            end else if (tick) begin
                // trigger edges while counting fall through unused
                if (match) begin
                    count_reg <= {W{1'b0}};
                    running_reg <= 1'b0;
                    irq_reg <= 1'b1;
                end else begin
                    count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // capture of the pre-tick count; stale once stopped or disabled
    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            capture_b_reg <= `CAPTURE_RESET;
        end else if (active & acap & tick) begin
            capture_b_reg <= count_reg;
        end
    end
endmodule // interval_trigger_timer

// ---- interval_trigger_timer_sva.sv ----
// port assertions for the interval timer
`timescale 1ns/10ps
module interval_trigger_timer_sva #(
    parameter W = 16
) (
    input wire I_CLK_SYS,
    input wire I_RST,
    input wire I_HSEL,
    input wire [31:0] I_HADDR,
    input wire [1:0] I_HTRANS,
    input wire I_HWRITE,
    input wire I_HREADY,
    input wire [31:0] O_HRDATA,
    input wire O_HREADYOUT,
    input wire O_HRESP,
    input wire O_MATCH_INTERRUPT
);
    wire rd = I_HSEL & I_HTRANS[1] & I_HREADY & ~I_HWRITE;
    wire wr = I_HSEL & I_HTRANS[1] & I_HREADY & I_HWRITE;
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    a_resp_okay: assert property (!O_HRESP) else $error("error response");
    a_read_wait: assert property (rd |=> !O_HREADYOUT ##1 O_HREADYOUT)
        else $error("read wait");
    a_write_nowait: assert property (wr |=> O_HREADYOUT) else $error("write wait");
    a_wait_cause: assert property (!O_HREADYOUT |-> $past(rd)) else $error("stray wait");
    // reset reloads the data, so the cycle after it is not compared
    a_data_hold: assert property (!$past(I_RST) && $past(O_HREADYOUT) |-> $stable(O_HRDATA))
        else $error("read data moved");
    a_unmapped_zero: assert property (rd && I_HADDR[7:2] > 6'h06 |=> ##1 O_HRDATA == 32'h0)
        else $error("unmapped data");
    a_count_width: assert property (rd && I_HADDR[7:2] == 6'h06 |=> ##1 O_HRDATA[31:W] == 0)
        else $error("count width");
    // fastest tick is every 8 clocks, except pin clock in low-speed mode (every 2), and compare is above 2
    a_irq_gap: assert property (O_MATCH_INTERRUPT |=> !O_MATCH_INTERRUPT [*7])
        else $error("irq pulse");
endmodule // interval_trigger_timer_sva
bind interval_trigger_timer interval_trigger_timer_sva #(.W(W)) u_sva (
    .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
    .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
    .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_MATCH_INTERRUPT(O_MATCH_INTERRUPT));

// ---- trigger_pulse_source.sv ----
// model of the pulse source on the trigger pin
`timescale 1ns/10ps
module trigger_pulse_source (
    input wire i_clk,
    output logic o_pin
);
    initial o_pin = 1'b0;
    // levels held 12+ clocks; shorter only for a commanded glitch
    task lvl(input logic v, input int n);
        @(posedge i_clk);
        o_pin <= v;
        repeat (n) @(posedge i_clk);
    endtask
endmodule // trigger_pulse_source

// ---- interval_and_trigger_timer_test.sv ----
// self-checking bench for the interval and trigger timer
`timescale 1ns/10ps
module interval_and_trigger_timer_test;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, lt = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, rdv, lf = 32'hc5e4;
    wire [31:0] hrdata;
    wire hready, irq, pin;
    int n_mismatch = 0, n_compared = 0, t, c;
    always #20 clk = ~clk;
    interval_trigger_timer u_interval_trigger_timer (.I_CLK_SYS(clk), .I_RST(rst),
        .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
        .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
        .O_HREADYOUT(hready), .O_HRESP(), .I_TRIGGER_INPUT_PIN(pin),
        .I_LOW_CLK_TICK(lt), .O_MATCH_INTERRUPT(irq));
    trigger_pulse_source u_trigger_pulse_source (.i_clk(clk), .o_pin(pin));
    function automatic logic [31:0] step(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    always @(posedge clk) begin
        lf <= step(lf);
        lt <= lf[0];
    end
    task report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task rdy;
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (hready !== 1'b1 && c < 50);
        if (c >= 50) begin
            n_mismatch++;
            report_and_stop;
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'h2;
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= {24'h0, a};
        rdy;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        rdv = hrdata;
    endtask
    task wirq(input int lim);
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (irq !== 1'b1 && t < lim);
    endtask
    task setcmp(input logic [15:0] v);
        int k;
        k = 0;
        bus(1, 8'h04, {24'h0, v[7:0]});
        bus(1, 8'h08, {24'h0, v[15:8]});
        do begin
            bus(0, 8'h14, 0);
            k++;
        end while (rdv[1] !== 1'b0 && k < 900);
        bus(0, 8'h0c, 0);
        chk(rdv, {16'h0, v}, "compare apply");
    endtask
    initial begin
        int sh, cv;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        bus(1, 8'h0c, 32'h1234);
        bus(0, 8'h10, 0);
        chk(rdv, 0, "capture reset");
        bus(0, 8'h1c, 0);
        chk(rdv, 0, "unmapped");
        bus(1, 8'h00, 32'h20);
        bus(1, 8'h04, 32'h55);
        repeat (20) @(posedge clk);
        bus(0, 8'h0c, 0);
        chk(rdv, 32'hffff, "low byte only");
        $display("test registers done");
        for (int s = 0; s < 3; s++) begin
            sh = s == 0 ? 11 : s == 1 ? 7 : 3;
            cv = 2 + lf[1:0];
            // stop with the old clock field, then change it while stopped
            bus(1, 8'h00, s == 0 ? 32'h20 : (s - 1) << 4);
            bus(1, 8'h00, s << 4);
            setcmp(cv[15:0]);
            bus(1, 8'h00, (s << 4) | 32'h44);
            wirq(20000);
            wirq(20000);
            chk(t, (cv + 1) << sh, "period");
            if (irq !== 1'b1)
                report_and_stop;
            bus(0, 8'h10, 0);
            chk(rdv, cv, "capture");
            $display("test timer clock %0d done", s);
        end
        bus(1, 8'h00, 32'h20);
        setcmp(16'h8);
        for (int e = 2; e < 4; e++)
            for (int m = 0; m < 2; m++) begin
                bus(1, 8'h00, 32'h20);
                u_trigger_pulse_source.lvl(e == 3, 20);
                bus(1, 8'h00, 32'h20 | (m << 7) | (e << 2));
                u_trigger_pulse_source.lvl(e == 2, 3);
                u_trigger_pulse_source.lvl(e == 3, 20);
                bus(0, 8'h14, 0);
                chk(rdv[0], 0, "glitch");
                u_trigger_pulse_source.lvl(e == 2, 14 + lf[1:0]);
                bus(0, 8'h14, 0);
                chk(rdv[0], 1, "start");
                u_trigger_pulse_source.lvl(e == 3, 0);
                wirq(100);
                chk(irq, m == 0, "opposite");
                bus(0, 8'h14, 0);
                chk(rdv[0], 0, "halt");
                u_trigger_pulse_source.lvl(e == 2, 14);
                u_trigger_pulse_source.lvl(e == 3, 14);
                u_trigger_pulse_source.lvl(e == 2, 14);
                // restart or ignored retrigger shows in the match time
                wirq(55);
                chk(irq, m == 0, "retrigger");
                if (m == 1) begin
                    wirq(80);
                    chk(irq, 1, "restart");
                end
                $display("test trigger %0d stop %0d done", e, m);
            end
        bus(1, 8'h00, 32'h20);
        bus(1, 8'h00, 32'h30);
        bus(1, 8'h00, 32'h34);
        for (int p = 0; p < 3; p++) begin
            u_trigger_pulse_source.lvl(1, 14);
            u_trigger_pulse_source.lvl(0, 14);
        end
        bus(0, 8'h18, 0);
        chk(rdv, 3, "pin clock count");
        $display("test pin clock done");
        bus(1, 8'h00, 32'h30);
        bus(1, 8'h00, 32'h200);
        bus(1, 8'h00, 32'h208);
        // a two-cycle pulse would be rejected with the filter in
        u_trigger_pulse_source.lvl(1, 1);
        u_trigger_pulse_source.lvl(0, 20);
        bus(0, 8'h14, 0);
        chk(rdv[0], 1, "bypass start");
        $display("test low speed bypass done");
        report_and_stop;
    end
endmodule // interval_and_trigger_timer_test
